// >>> sfcr_defs.vh
`ifndef SFCR_DEFS_VH
`define SFCR_DEFS_VH
// opcodes
`define SFCR_OP_READ_MAX 8'h1b
`define SFCR_OP_READ_STD 8'h0b
`define SFCR_OP_READ_LOW 8'h03
`define SFCR_OP_READ_DUAL 8'h3b
`define SFCR_OP_ERASE_4K 8'h20
`define SFCR_OP_ERASE_32K 8'h52
`define SFCR_OP_ERASE_64K 8'hd8
`define SFCR_OP_CHIP_ERASE_A 8'h60
`define SFCR_OP_CHIP_ERASE_B 8'hc7
`define SFCR_OP_PROG 8'h02
`define SFCR_OP_PROG_DUAL 8'ha2
`define SFCR_OP_SUSPEND 8'hb0
`define SFCR_OP_RESUME 8'hd0
`define SFCR_OP_WR_EN 8'h06
`define SFCR_OP_WR_DIS 8'h04
`define SFCR_OP_PROTECT 8'h36
`define SFCR_OP_UNPROTECT 8'h39
`define SFCR_OP_RD_PROT 8'h3c
`define SFCR_OP_LOCKDOWN 8'h33
`define SFCR_OP_FREEZE 8'h34
`define SFCR_OP_RD_LOCK 8'h35
`define SFCR_OP_OTP_PROG 8'h9b
`define SFCR_OP_OTP_READ 8'h77
`define SFCR_OP_RD_STATUS 8'h05
`define SFCR_OP_WR_STATUS1 8'h01
`define SFCR_OP_WR_STATUS2 8'h31
`define SFCR_OP_SW_RESET 8'hf0
`define SFCR_OP_READ_ID 8'h9f
`define SFCR_OP_PWR_DOWN 8'hb9
`define SFCR_OP_PWR_UP 8'hab
// address layout
`define SFCR_ADDR_BYTES 2'd3
`define SFCR_ARRAY_AW 20
`define SFCR_ARRAY_LAST 20'hfffff
// read clock limits, MHz
`define SFCR_LOW_SPEED_READ_CLOCK_LIMIT 40
`define SFCR_STD_READ_CLOCK_LIMIT 85
`define SFCR_MAX_READ_CLOCK_LIMIT 100
`endif

// >>> sfcr_decode.v
`timescale 1ns/1ps
`include "sfcr_defs.vh"
// opcode table: supported flag, address/dummy counts and read class
module sfcr_decode (
  input wire [7:0] opcode,
  output reg valid,
  output reg has_addr,
  output reg [1:0] dummy_bytes,
  output reg is_array_read,
  output reg is_dual_read
);
  always @* begin
    valid = 1'b1;
    has_addr = 1'b0;
    dummy_bytes = 2'd0;
    is_array_read = 1'b0;
    is_dual_read = 1'b0;
    case (opcode)
      `SFCR_OP_READ_MAX: begin
        has_addr = 1'b1;
        dummy_bytes = 2'd2;
        is_array_read = 1'b1;
      end
      `SFCR_OP_READ_STD: begin
        has_addr = 1'b1;
        dummy_bytes = 2'd1;
        is_array_read = 1'b1;
      end
      `SFCR_OP_READ_LOW: begin
        has_addr = 1'b1;
        is_array_read = 1'b1;
      end
      `SFCR_OP_READ_DUAL: begin
        has_addr = 1'b1;
        dummy_bytes = 2'd1;
        is_array_read = 1'b1;
        is_dual_read = 1'b1;
      end
      `SFCR_OP_PROG, `SFCR_OP_PROG_DUAL: has_addr = 1'b1;
      `SFCR_OP_ERASE_4K, `SFCR_OP_ERASE_32K, `SFCR_OP_ERASE_64K: has_addr = 1'b1;
      `SFCR_OP_CHIP_ERASE_A, `SFCR_OP_CHIP_ERASE_B, `SFCR_OP_SUSPEND, `SFCR_OP_RESUME: has_addr = 1'b0;
      `SFCR_OP_WR_EN, `SFCR_OP_WR_DIS: has_addr = 1'b0;
      `SFCR_OP_PROTECT, `SFCR_OP_UNPROTECT, `SFCR_OP_RD_PROT: has_addr = 1'b1;
      `SFCR_OP_RD_STATUS, `SFCR_OP_WR_STATUS1, `SFCR_OP_WR_STATUS2: has_addr = 1'b0;
      `SFCR_OP_LOCKDOWN, `SFCR_OP_FREEZE, `SFCR_OP_RD_LOCK: has_addr = 1'b1;
      `SFCR_OP_OTP_PROG: has_addr = 1'b1;
      `SFCR_OP_OTP_READ: begin
        has_addr = 1'b1;
        dummy_bytes = 2'd2;
      end
      `SFCR_OP_READ_ID, `SFCR_OP_SW_RESET: has_addr = 1'b0;
      `SFCR_OP_PWR_DOWN, `SFCR_OP_PWR_UP: has_addr = 1'b0;
      default: valid = 1'b0;
    endcase
  end
endmodule // sfcr_decode

// >>> sfcr_cmd_read.v
`timescale 1ns/1ps
`include "sfcr_defs.vh"
// Notes on behaviour
// - chip select low, then one opcode byte
// - every byte travels msb first
// - chip select high ends the frame
// - unknown opcode ignored until next frame
// - early chip select rise performs nothing
// - three address bytes, top four ignored
// - opcode 1bh needs two dummy bytes
// - opcode 0bh needs one dummy byte
// - opcode 03h has no dummy, slow clock
// - data streams out, address auto-increments
// - wrap from last byte to zero seamlessly
// - chip select high tristates outputs immediately
// - program 02h and a2h take address
// - erase, suspend and resume decoded
// - write enable and protection decoded
// - status read and writes decoded
// - lockdown commands take address and data
// - otp program takes address, otp read adds two dummies
// - id read and software reset decoded
// - power-down enter and exit decoded
// - dual read 3bh needs one dummy
// - dual read drives two bits per clock
// - sample rising edge, drive falling edge
module sfcr_cmd_read #(
  parameter AW = `SFCR_ARRAY_AW
) (
  input wire ref_clk,
  input wire arst_n,
  input wire sck,
  input wire cs_n,
  input wire si_in,
  input wire so_in,
  output reg so_out_q,
  output reg so_oe_q,
  output reg second_dual_data_line_out_q,
  output reg second_dual_data_line_oe_q,
  output reg [7:0] opcode_q,
  output reg cmd_valid_q,
  output reg [AW-1:0] addr_q,
  output reg [7:0] rx_byte_q,
  output reg rx_byte_stb_q,
  output reg frame_end_stb_q,
  output reg frame_complete_q,
  output reg mem_req_q,
  output reg [AW-1:0] mem_addr_q,
  input wire [7:0] mem_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // frame phases
  localparam ST_IDLE = 3'd0;
  localparam ST_OPCODE = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_DUMMY = 3'd3;
  localparam ST_DATA = 3'd4;
  localparam ST_IGNORE = 3'd5;

  // phase register, edge history and byte framing
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg sck_q;
  reg cs_n_q;
  reg [2:0] bit_cnt_q;
  reg [1:0] byte_cnt_q;
  reg [7:0] shift_q;
  reg [1:0] dummy_left_q;
  reg dual_q;
  reg array_rd_q;
  reg [7:0] tx_q;
  reg [AW-1:0] rd_addr_q;
  reg [23:0] addr_shift_q;
  // dual-input program receive path
  reg dual_in_q;
  reg [1:0] din_cnt_q;
  reg [7:0] din_shift_q;
  reg [7:0] din_byte_q;
  reg din_stb_q;

  // combinational helpers
  wire sck_rise;
  wire sck_fall;
  wire [7:0] shift_next;
  wire byte_done;
  wire dec_valid;
  wire dec_has_addr;
  wire [1:0] dec_dummy;
  wire dec_array;
  wire dec_dual;
  wire [AW-1:0] addr_next;
  wire [7:0] din_next;

  // sck and cs are taken as synchronous to ref_clk; edges from one-cycle history
  assign sck_rise = sck & ~sck_q & ~cs_n;
  assign sck_fall = ~sck & sck_q & ~cs_n;
  assign shift_next = {shift_q[6:0], si_in};
  assign byte_done = sck_rise & (bit_cnt_q == 3'd7);
  // natural overflow gives the wrap from last location to zero
  // the counter spans the array exactly, so no compare is needed
  assign addr_next = rd_addr_q + {{(AW-1){1'b0}}, 1'b1};
  // dual input: so_in carries the upper bit of each pair
  assign din_next = {din_shift_q[5:0], so_in, si_in};

  // decode the byte as it completes, so the next phase starts on time
  sfcr_decode u_decode (
    .opcode(shift_next),
    .valid(dec_valid),
    .has_addr(dec_has_addr),
    .dummy_bytes(dec_dummy),
    .is_array_read(dec_array),
    .is_dual_read(dec_dual)
  );

  ////////////////////////////////////////////////////////////////////////
  // phase sequencing
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (!cs_n) begin
          state_d = ST_OPCODE;
        end
      end
      ST_OPCODE: begin
        if (byte_done) begin
          if (!dec_valid) begin
            state_d = ST_IGNORE;
          end else if (dec_has_addr) begin
            state_d = ST_ADDR;
          end else begin
            state_d = ST_DATA;
          end
        end
      end
      ST_ADDR: begin
        // the dummy count was latched together with the opcode
        if (byte_done && byte_cnt_q == `SFCR_ADDR_BYTES - 2'd1) begin
          state_d = (dummy_left_q != 2'd0) ? ST_DUMMY : ST_DATA;
        end
      end
      ST_DUMMY: begin
        if (byte_done && dummy_left_q == 2'd1) begin
          state_d = ST_DATA;
        end
      end
      ST_DATA: state_d = ST_DATA;
      // unknown opcode: sit out the frame, only cs high leaves
      ST_IGNORE: state_d = ST_IGNORE;
      default: state_d = ST_IDLE;
    endcase
    // chip select high aborts any phase, even mid-byte
    if (cs_n) begin
      state_d = ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input shifting, counters and command capture
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      bit_cnt_q <= 3'd0;
      byte_cnt_q <= 2'd0;
      shift_q <= 8'h00;
      dummy_left_q <= 2'd0;
      dual_q <= 1'b0;
      array_rd_q <= 1'b0;
      opcode_q <= 8'h00;
      cmd_valid_q <= 1'b0;
      addr_q <= {AW{1'b0}};
      addr_shift_q <= 24'h000000;
      rx_byte_q <= 8'h00;
      rx_byte_stb_q <= 1'b0;
      frame_end_stb_q <= 1'b0;
      frame_complete_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sck_q <= sck;
      cs_n_q <= cs_n;
      rx_byte_stb_q <= 1'b0;
      frame_end_stb_q <= 1'b0;
      // rising cs edge ends the frame; flag whether command info was complete
      // later blocks act on this flag, so it must not depend on a full byte
      if (cs_n && !cs_n_q) begin
        frame_end_stb_q <= 1'b1;
        frame_complete_q <= cmd_valid_q && (state_q == ST_DATA);
      end
      if (state_d == ST_IDLE) begin
        bit_cnt_q <= 3'd0;
        byte_cnt_q <= 2'd0;
        dual_q <= 1'b0;
        array_rd_q <= 1'b0;
        if (!cs_n_q || cs_n) begin
          cmd_valid_q <= cmd_valid_q & ~cs_n;
        end
      end else if (sck_rise && state_q != ST_IGNORE) begin
        bit_cnt_q <= bit_cnt_q + 3'd1;
        shift_q <= shift_next;
        if (bit_cnt_q == 3'd7) begin
          case (state_q)
            ST_OPCODE: begin
              opcode_q <= shift_next;
              cmd_valid_q <= dec_valid & ~dec_has_addr;
              dummy_left_q <= dec_dummy;
              dual_q <= dec_dual;
              array_rd_q <= dec_array;
            end
            ST_ADDR: begin
              addr_shift_q <= {addr_shift_q[15:0], shift_next};
              byte_cnt_q <= byte_cnt_q + 2'd1;
              if (byte_cnt_q == `SFCR_ADDR_BYTES - 2'd1) begin
                // upper four address bits dropped
                addr_q <= {addr_shift_q[AW-9:0], shift_next};
                cmd_valid_q <= 1'b1;
              end
            end
            ST_DUMMY: dummy_left_q <= dummy_left_q - 2'd1;
            ST_DATA: begin
              // dual-input bytes come through the separate receive path
              if (!dual_in_q) begin
                rx_byte_q <= shift_next;
                rx_byte_stb_q <= 1'b1;
              end
            end
            default: dummy_left_q <= dummy_left_q;
          endcase
        end
      end
      // finished dual-input byte handed over a cycle late; the single
      // line path stays quiet for that opcode, so the two never clash
      if (din_stb_q) begin
        rx_byte_q <= din_byte_q;
        rx_byte_stb_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dual-input program data: two bits per rising sck, upper bit on so_in
  // own counter keeps the four-rise byte apart from the eight-rise
  // single-line framing, at the cost of one extra cycle of latency
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dual_in_q <= 1'b0;
      din_cnt_q <= 2'd0;
      din_shift_q <= 8'h00;
      din_byte_q <= 8'h00;
      din_stb_q <= 1'b0;
    end else begin
      din_stb_q <= 1'b0;
      if (state_d == ST_IDLE) begin
        // pair count and dual flag clear with the frame, so a cut frame leaves no half byte
        dual_in_q <= 1'b0;
        din_cnt_q <= 2'd0;
      end else if (state_q == ST_OPCODE && byte_done) begin
        dual_in_q <= (shift_next == `SFCR_OP_PROG_DUAL);
        din_cnt_q <= 2'd0;
      end else if (state_q == ST_DATA && dual_in_q && sck_rise) begin
        din_shift_q <= din_next;
        din_cnt_q <= din_cnt_q + 2'd1;
        if (din_cnt_q == 2'd3) begin
          din_byte_q <= din_next;
          din_stb_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array read stream: fetch on entry, prefetch next byte during transmit
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      so_out_q <= 1'b0;
      so_oe_q <= 1'b0;
      second_dual_data_line_out_q <= 1'b0;
      second_dual_data_line_oe_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_addr_q <= {AW{1'b0}};
      rd_addr_q <= {AW{1'b0}};
      tx_q <= 8'h00;
    end else begin
      mem_req_q <= 1'b0;
      if (cs_n) begin
        // drop drivers the cycle cs rises, no full byte needed
        so_oe_q <= 1'b0;
        second_dual_data_line_oe_q <= 1'b0;
        // park data low so a stale bit never leaks into the next frame
        so_out_q <= 1'b0;
        second_dual_data_line_out_q <= 1'b0;
      end else if (state_q != ST_DATA && state_d == ST_DATA && array_rd_q) begin
        // first fetch on entry; with no dummies the address is still in the shifter
        rd_addr_q <= (state_q == ST_ADDR) ? {addr_shift_q[AW-9:0], shift_next} : addr_q;
        mem_addr_q <= (state_q == ST_ADDR) ? {addr_shift_q[AW-9:0], shift_next} : addr_q;
        mem_req_q <= 1'b1;
      end else if (state_q == ST_DATA && array_rd_q && sck_fall) begin
        // mem_rdata presumed valid one ref_clk after mem_req_q, well before the first fall
        // the array side must hold its word until the next request
        if (dual_q) begin
          // two bits per sck fall, msb on so
          // a new byte starts every fourth fall, so prefetch runs twice as often
          if (bit_cnt_q[1:0] == 2'd0) begin
            so_out_q <= mem_rdata[7];
            second_dual_data_line_out_q <= mem_rdata[6];
            tx_q <= {mem_rdata[5:0], 2'b00};
            rd_addr_q <= addr_next;
            mem_addr_q <= addr_next;
            mem_req_q <= 1'b1;
          end else begin
            so_out_q <= tx_q[7];
            second_dual_data_line_out_q <= tx_q[6];
            tx_q <= {tx_q[5:0], 2'b00};
          end
          so_oe_q <= 1'b1;
          second_dual_data_line_oe_q <= 1'b1;
        end else begin
          if (bit_cnt_q == 3'd0) begin
            so_out_q <= mem_rdata[7];
            tx_q <= {mem_rdata[6:0], 1'b0};
            rd_addr_q <= addr_next;
            mem_addr_q <= addr_next;
            mem_req_q <= 1'b1;
          end else begin
            so_out_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
          so_oe_q <= 1'b1;
        end
      end
    end
  end

endmodule // sfcr_cmd_read

// >>> sfcr_cmd_read_sva.sv
`timescale 1ns/1ps
`include "sfcr_defs.vh"
module sfcr_cmd_read_sva #(
  parameter AW = 20
) (
  input wire ref_clk,
  input wire arst_n,
  input wire sck,
  input wire cs_n,
  input wire so_out_q,
  input wire so_oe_q,
  input wire second_dual_data_line_oe_q,
  input wire [7:0] opcode_q,
  input wire cmd_valid_q,
  input wire [AW-1:0] addr_q,
  input wire frame_end_stb_q,
  input wire rx_byte_stb_q,
  input wire mem_req_q,
  input wire [AW-1:0] mem_addr_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  reg [AW-1:0] last_q;
  reg seen_q;
  wire rd_op = opcode_q == `SFCR_OP_READ_LOW || opcode_q == `SFCR_OP_READ_STD ||
    opcode_q == `SFCR_OP_READ_MAX || opcode_q == `SFCR_OP_READ_DUAL;
  ////////////////////////////////////////////////////////////////////////
  // last fetch address, forgotten between frames so a new start is free
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_q <= {AW{1'b0}};
      seen_q <= 1'b0;
    end else if (cs_n) begin
      seen_q <= 1'b0;
    end else if (mem_req_q) begin
      last_q <= mem_addr_q;
      seen_q <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // a low-speed read header completes, then the first fetch follows
  sequence s_rd_start;
    $rose(cmd_valid_q) ##0 (opcode_q == `SFCR_OP_READ_LOW);
  endsequence
  sequence s_cs_up;
    $rose(cs_n);
  endsequence
  first_req_a: assert property (s_rd_start |-> ##[0:20] (mem_req_q && mem_addr_q == addr_q))
    else $error("first fetch address wrong");
  end_stb_a: assert property (s_cs_up |-> ##[1:4] frame_end_stb_q)
    else $error("no frame end pulse");
  end_pulse_a: assert property (frame_end_stb_q |=> !frame_end_stb_q)
    else $error("frame end pulse too long");
  oe_off_a: assert property (cs_n [*4] |-> !so_oe_q && !second_dual_data_line_oe_q)
    else $error("output driven while deselected");
  dual_only_a: assert property (second_dual_data_line_oe_q |-> opcode_q == `SFCR_OP_READ_DUAL)
    else $error("second line driven outside dual read");
  req_read_a: assert property (mem_req_q |-> rd_op)
    else $error("fetch outside array read");
  oe_valid_a: assert property (so_oe_q && !cs_n |-> cmd_valid_q)
    else $error("output driven without valid command");
  so_hold_a: assert property (sck [*4] |-> $stable(so_out_q))
    else $error("output changed while clock high");
  mem_seq_a: assert property (mem_req_q && seen_q |-> mem_addr_q == last_q + 1'b1)
    else $error("fetch address did not step by one");
  rx_stb_a: assert property (rx_byte_stb_q |-> cmd_valid_q && !cs_n)
    else $error("data byte reported outside a valid frame");
endmodule // sfcr_cmd_read_sva

bind sfcr_cmd_read sfcr_cmd_read_sva #(.AW(AW)) i_sva (.ref_clk, .arst_n, .sck, .cs_n, .so_out_q, .so_oe_q,
  .second_dual_data_line_oe_q, .opcode_q, .cmd_valid_q, .addr_q, .frame_end_stb_q, .rx_byte_stb_q, .mem_req_q,
  .mem_addr_q);

// >>> sfcr_host_model.sv
`timescale 1ns/1ps
module sfcr_host_model (
  input wire ref_clk,
  input wire so_out_q,
  input wire second_dual_data_line_out_q,
  output reg sck,
  output reg cs_n,
  output reg si_in
);
  reg rs;
  reg rs2;
  // mode 0: clock parks low outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si_in = 1'b0;
    rs = 1'b0;
    rs2 = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one clock: fall, long low phase so output settles, sample, rise
  task xbit(input b);
    begin
      @(negedge ref_clk);
      sck = 1'b0;
      si_in = b;
      repeat (5) @(negedge ref_clk); // ten ref_clk per sck, far below any read limit
      rs = so_out_q;
      rs2 = second_dual_data_line_out_q;
      sck = 1'b1;
      repeat (4) @(negedge ref_clk);
    end
  endtask
  // byte out and in together, msb first
  task xbyte(input [7:0] d, output [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        xbit(d[i]);
        r[i] = rs;
      end
    end
  endtask
  task start;
    begin
      @(negedge ref_clk);
      cs_n = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
  endtask
  // released data line flips so a stale level is never trusted
  task stop;
    begin
      @(negedge ref_clk);
      sck = 1'b0;
      si_in = ~si_in;
      repeat (4) @(negedge ref_clk);
      cs_n = 1'b1;
      repeat (10) @(negedge ref_clk);
    end
  endtask
endmodule // sfcr_host_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg ref_clk;
  reg arst_n;
  wire sck;
  wire cs_n;
  wire si_in;
  wire so_out_q;
  wire so_oe_q;
  wire sd_q;
  wire [7:0] opcode_q;
  wire cmd_valid_q;
  wire [19:0] addr_q;
  wire [7:0] rx_byte_q;
  wire frame_complete_q;
  wire [19:0] mem_addr_q;
  wire [7:0] mem_rdata;
  reg so_drv;
  wire sd_oe;
  wire so_pin;
  wire sd_pin;
  // released lines float to their pull-up level, never the last bit
  assign so_pin = so_oe_q ? so_out_q : 1'b1;
  assign sd_pin = sd_oe ? sd_q : 1'b1;
  integer n_mismatch;
  integer n_checks;
  localparam [103:0] ops_n = 104'h60c7b0d006040501_31f09fb9ab;
  localparam [103:0] ops_a = 104'h2052d802a236393c_3334359b77;
  function [7:0] pat(input [19:0] a);
    pat = a[7:0] + {a[19:16], 4'h3};
  endfunction
  // array stand-in: data follows the registered fetch address
  assign mem_rdata = pat(mem_addr_q);
  sfcr_cmd_read #(.AW(20)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n),
    .si_in(si_in), .so_in(so_drv), .so_out_q(so_out_q), .so_oe_q(so_oe_q), .second_dual_data_line_out_q(sd_q),
    .second_dual_data_line_oe_q(sd_oe), .opcode_q(opcode_q), .cmd_valid_q(cmd_valid_q), .addr_q(addr_q),
    .rx_byte_q(rx_byte_q), .rx_byte_stb_q(), .frame_end_stb_q(), .frame_complete_q(frame_complete_q),
    .mem_req_q(), .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata));
  sfcr_host_model i_host (.ref_clk(ref_clk), .so_out_q(so_pin), .second_dual_data_line_out_q(sd_pin),
    .sck(sck), .cs_n(cs_n), .si_in(si_in));
  ////////////////////////////////////////////////////////////////////////
  task chk(input [19:0] got, input [19:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // read from the last bytes across the wrap, top nibble set, cut mid-byte
  task t_read(input [7:0] op, input integer nd);
    integer k;
    reg [7:0] r;
    begin
      i_host.start;
      i_host.xbyte(op, r);
      i_host.xbyte(8'hff, r);
      i_host.xbyte(8'hff, r);
      i_host.xbyte(8'hfe, r);
      chk(addr_q, 20'hffffe);
      chk(cmd_valid_q, 20'h1);
      for (k = 0; k < nd; k = k + 1) i_host.xbyte(8'h00, r);
      for (k = 0; k < 3; k = k + 1) begin
        i_host.xbyte(8'h00, r);
        chk(r, pat(20'hffffe + k));
      end
      i_host.xbit(1'b1);
      i_host.stop;
      chk(so_oe_q, 20'h0);
      chk(frame_complete_q, 20'h1);
    end
  endtask
  // dual read: two bits per clock, upper bit on the normal line
  task t_dual;
    integer k;
    reg [7:0] r;
    begin
      i_host.start;
      i_host.xbyte(8'h3b, r);
      i_host.xbyte(8'h00, r);
      i_host.xbyte(8'h00, r);
      i_host.xbyte(8'h10, r);
      i_host.xbyte(8'h00, r);
      for (k = 0; k < 8; k = k + 1) begin
        i_host.xbit(k[0]);
        r[7 - 2 * (k % 4)] = i_host.rs;
        r[6 - 2 * (k % 4)] = i_host.rs2;
        if (k % 4 == 3) chk(r, pat(20'h10 + k / 4));
      end
      i_host.stop;
      chk(sd_oe, 20'h0);
    end
  endtask
  // refused frame: unknown opcode or header cut short
  task t_refuse(input [7:0] op, input integer nb);
    integer k;
    reg [7:0] r;
    begin
      i_host.start;
      i_host.xbyte(op, r);
      for (k = 0; k < nb; k = k + 1) i_host.xbyte(8'h03, r);
      chk(cmd_valid_q, 20'h0);
      chk(so_oe_q, 20'h0);
      i_host.stop;
      chk(frame_complete_q, 20'h0);
    end
  endtask
  // every other opcode of the table, with and without address
  task t_ops;
    integer i;
    integer j;
    reg [7:0] op;
    reg [7:0] r;
    begin
      for (i = 0; i < 26; i = i + 1) begin
        op = (i < 13) ? ops_n[8 * i +: 8] : ops_a[8 * i - 104 +: 8];
        so_drv = (op == 8'ha2);
        i_host.start;
        i_host.xbyte(op, r);
        for (j = 0; j < 3 && i >= 13; j = j + 1) i_host.xbyte(8'h5a, r);
        if (i >= 13) chk(addr_q, 20'ha5a5a);
        chk(cmd_valid_q, 20'h1);
        chk(opcode_q, op);
        i_host.xbyte(8'hc5, r);
        if (op == 8'h02) chk(rx_byte_q, 20'hc5);
        if (op == 8'ha2) chk(rx_byte_q, 20'hbb);
        i_host.stop;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // watchdog well beyond the roughly 12k cycles the sequence needs
  initial begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    so_drv = 1'b0;
    arst_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    t_read(8'h1b, 2);
    t_read(8'h0b, 1);
    t_read(8'h03, 0);
    t_dual;
    t_refuse(8'hff, 4);
    t_refuse(8'h03, 2);
    t_ops;
    t_read(8'h03, 0);
    test_done;
  end
endmodule // tb_top
